// *** dvic_ctrl.sv ***
// Top of the dual vectored interrupt controller
`timescale 1ns/100ps
// Notes on behaviour
// - 32 channels from primary and secondary units
// - Fast and normal outputs, fast has precedence
// - Any input may route to fast output
// - Normal request is OR of channels
// - Lower channel number wins priority
// - Firmware remaps sources within one unit
// - Primary unit outranks secondary unit always
// - Resolve winner; core reads source and vector
// - Dedicated cache entry holds vector-read instruction
// - Firmware may force request on any channel
module dvic_ctrl #(
	parameter int CHANNELS = dvic_pkg::CHANNELS,
	parameter int VEC_W = dvic_pkg::VEC_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Request lines from peripherals, asynchronous levels
	input wire logic [CHANNELS-1:0] req_in,
	// Firmware configuration
	input wire logic [CHANNELS-1:0] soft_req,
	input wire logic [CHANNELS-1:0] chan_enable,
	input wire logic [CHANNELS-1:0] fast_select,
	input wire logic [CHANNELS*dvic_pkg::SEL_W-1:0] channel_source,
	// Vector words per channel and the cached read instruction
	input wire logic [CHANNELS*VEC_W-1:0] vector_table,
	input wire logic [VEC_W-1:0] vector_read_insn,
	// Core side
	input wire logic vector_read,
	// Answer to the core
	output logic fast_request,
	output logic normal_request,
	output logic [dvic_pkg::CHAN_W-1:0] source_id,
	output logic [VEC_W-1:0] vector_addr,
	output logic [VEC_W-1:0] branch_cache_entry,
	output logic in_service
);
	// Channels per unit and width of one remap field
	localparam int U = dvic_pkg::UNIT_CHANNELS;
	localparam int S = dvic_pkg::SEL_W;

	// Synchroniser stages
	logic [CHANNELS-1:0] req_meta_q;
	logic [CHANNELS-1:0] req_sync_q;

	// Results of the two units
	logic [U-1:0] p_active;
	logic [U-1:0] s_active;
	logic p_any;
	logic s_any;
	logic p_fast;
	logic s_fast;
	logic [S-1:0] p_win;
	logic [S-1:0] s_win;

	// Combined next values and service state
	logic vec_any;
	logic [dvic_pkg::CHAN_W-1:0] win_d;
	logic fast_d;
	logic normal_d;
	dvic_pkg::dvic_service_type state_q;

	// Channel number across both units: top bit says which unit
	function automatic logic [dvic_pkg::CHAN_W-1:0] global_channel(input logic in_second,
			input logic [S-1:0] unit_win);
		return {in_second, unit_win};
	endfunction

	// Vector word of one channel, picked out of the flat table
	function automatic logic [VEC_W-1:0] vector_of(input logic [dvic_pkg::CHAN_W-1:0] chan,
			input logic [CHANNELS*VEC_W-1:0] vectors);
		return vectors[chan*VEC_W +: VEC_W];
	endfunction

	// True while an answer is latched for the core
	function automatic logic serving(input dvic_pkg::dvic_service_type st);
		return st == dvic_pkg::DVIC_SERVICE_ACTIVE;
	endfunction

	// Two-stage synchroniser on the raw request pins
	// Only the second stage feeds logic; the first may still be settling
	always_ff @(posedge clock) begin
		if (reset) begin
			req_meta_q <= '0;
			req_sync_q <= '0;
		end else begin
			req_meta_q <= req_in;
			req_sync_q <= req_meta_q;
		end
	end

	// Primary unit, channels 0 to 15
	// Remap fields hold local source numbers, so a remap never crosses units
	dvic_unit #(.N(U), .SEL_W(S)) u_primary (
		.source_req(req_sync_q[U-1:0]),
		.soft_req(soft_req[U-1:0]),
		.enable(chan_enable[U-1:0]),
		.fast_select(fast_select[U-1:0]),
		.channel_source(channel_source[U*S-1:0]),
		.chan_active(p_active),
		.any_active(p_any),
		.winner(p_win),
		.fast_any(p_fast)
	);

	// Secondary unit, channels 16 to 31, daisy-chained below the primary
	dvic_unit #(.N(U), .SEL_W(S)) u_secondary (
		.source_req(req_sync_q[CHANNELS-1:U]),
		.soft_req(soft_req[CHANNELS-1:U]),
		.enable(chan_enable[CHANNELS-1:U]),
		.fast_select(fast_select[CHANNELS-1:U]),
		.channel_source(channel_source[CHANNELS*S-1:U*S]),
		.chan_active(s_active),
		.any_active(s_any),
		.winner(s_win),
		.fast_any(s_fast)
	);

	// Any vectored channel in either unit; fast-routed channels are already left out
	assign vec_any = p_any | s_any;

	// Combined winner: primary always beats secondary
	// The secondary is looked at only while the primary is quiet, as in a daisy chain
	always_comb begin
		win_d = dvic_pkg::NO_CHANNEL;
		if (p_any) begin
			win_d = global_channel(1'b0, p_win);
		end else if (s_any) begin
			win_d = global_channel(1'b1, s_win);
		end
	end

	// Fast outranks normal; a pending fast request holds off the normal line
	// Masking normal delays vectored service but the core never sees both at once
	assign fast_d = p_fast | s_fast;
	assign normal_d = vec_any & ~fast_d;

	// Output requests follow the sampled levels, dropping once idle
	// Both start low after reset so the core sees no false request
	always_ff @(posedge clock) begin
		if (reset) begin
			fast_request <= 1'b0;
			normal_request <= 1'b0;
		end else begin
			fast_request <= fast_d;
			normal_request <= normal_d;
		end
	end

	// Source registered with the winner; frozen while the core reads
	// A later, higher request waits until service ends, so the answer stays consistent
	always_ff @(posedge clock) begin
		if (reset) begin
			source_id <= dvic_pkg::NO_CHANNEL;
		end else if (!serving(state_q)) begin
			source_id <= win_d;
		end
	end

	// Vector of the same winner, zero when nothing is pending
	always_ff @(posedge clock) begin
		if (reset) begin
			vector_addr <= dvic_pkg::VECTOR_RESET;
		end else if (!serving(state_q)) begin
			vector_addr <= vec_any ? vector_of(win_d, vector_table) : dvic_pkg::VECTOR_RESET;
		end
	end

	// Service tracking: a vector read latches the answer until no vectored channel in either unit is active
	// A read outside the pending state is ignored
	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= dvic_pkg::DVIC_SERVICE_IDLE;
		end else begin
			unique case (state_q)
				dvic_pkg::DVIC_SERVICE_IDLE: begin
					// Wait for the core once the normal line goes up
					if (normal_d) begin
						state_q <= dvic_pkg::DVIC_SERVICE_PENDING;
					end
				end
				dvic_pkg::DVIC_SERVICE_PENDING: begin
					if (vector_read) begin
						state_q <= dvic_pkg::DVIC_SERVICE_ACTIVE;
					end else if (!normal_d) begin
						// Withdrawn before the core read it: nothing to latch
						state_q <= dvic_pkg::DVIC_SERVICE_IDLE;
					end
				end
				dvic_pkg::DVIC_SERVICE_ACTIVE: begin
					// Released once no vectored channel in either unit is asserting
					if (!vec_any) begin
						state_q <= dvic_pkg::DVIC_SERVICE_IDLE;
					end
				end
				default: begin
					// Unused code: fall back to idle rather than lock up
					state_q <= dvic_pkg::DVIC_SERVICE_IDLE;
				end
			endcase
		end
	end

	// Service flag for the core, a cycle behind the state so it comes from a flip-flop
	always_ff @(posedge clock) begin
		if (reset) begin
			in_service <= 1'b0;
		end else begin
			in_service <= serving(state_q);
		end
	end

	// Dedicated cache entry keeps the vector-read instruction ready at all times
	// Loaded every cycle, so a new instruction word shows one cycle later
	always_ff @(posedge clock) begin
		if (reset) begin
			branch_cache_entry <= dvic_pkg::VECTOR_READ_INSN_RESET;
		end else begin
			branch_cache_entry <= vector_read_insn;
		end
	end
endmodule

// *** dvic_pkg.sv ***
// Package with constants for the dual vectored interrupt controller
package dvic_pkg;
	localparam int CHANNELS = 32;
	localparam int UNIT_CHANNELS = 16;
	localparam int CHAN_W = 5;
	localparam int SEL_W = 4;
	localparam int VEC_W = 32;
	localparam logic [CHAN_W-1:0] NO_CHANNEL = 5'h1f;
	localparam logic [VEC_W-1:0] VECTOR_RESET = 32'h0000_0000;
	localparam logic [VEC_W-1:0] VECTOR_READ_INSN_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {
		DVIC_SERVICE_IDLE,
		DVIC_SERVICE_PENDING,
		DVIC_SERVICE_ACTIVE
	} dvic_service_type;
endpackage

// *** dvic_unit.sv ***
// One sixteen-channel vectored unit: source remap, software force, priority search
`timescale 1ns/100ps
module dvic_unit #(
	parameter int N = 16,
	parameter int SEL_W = 4
) (
	// Requests
	input wire logic [N-1:0] source_req,
	input wire logic [N-1:0] soft_req,
	input wire logic [N-1:0] enable,
	input wire logic [N-1:0] fast_select,
	// Channel to source mapping, one field per channel
	input wire logic [N*SEL_W-1:0] channel_source,
	// Results
	output logic [N-1:0] chan_active,
	output logic any_active,
	output logic [SEL_W-1:0] winner,
	output logic fast_any
);
	logic [N-1:0] forced;

	// Software force is ORed in like a hardware source, but without the two synchroniser stages
	assign forced = source_req | soft_req;

	// Each hardware channel picks its source through the remap field
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_chan
			logic [SEL_W-1:0] sel;
			assign sel = channel_source[g*SEL_W +: SEL_W];
			assign chan_active[g] = forced[sel] & enable[g] & ~fast_select[g];
		end
	endgenerate

	// Fast path takes any fast-selected source, enable not applied, no priority needed
	assign fast_any = |(forced & fast_select);

	assign any_active = |chan_active;

	// Lowest channel number wins
	always_comb begin
		winner = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (chan_active[i]) begin
				winner = SEL_W'(i);
			end
		end
	end
endmodule

// *** dvic_ctrl_props.sv ***
// Checker for the dual vectored interrupt controller
`timescale 1ns/100ps
module dvic_ctrl_props (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Requests
	input wire logic [31:0] req_in,
	input wire logic [31:0] soft_req,
	input wire logic [31:0] chan_enable,
	input wire logic [31:0] fast_select,
	input wire logic [31:0] vector_read_insn,
	// Core side
	input wire logic vector_read,
	input wire logic fast_request,
	input wire logic normal_request,
	input wire logic [4:0] source_id,
	input wire logic [31:0] branch_cache_entry,
	input wire logic in_service
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Service steps: read taken while pending, then latched
	sequence s_read; vector_read && normal_request && !in_service; endsequence
	sequence s_latch; ##2 in_service; endsequence
	a_reset_idle: assert property ($fell(reset) |-> !normal_request && !fast_request && source_id == 5'h1f)
		else $error("not idle after reset");
	a_quiet_idle: assert property ((req_in | soft_req) == 32'h0 [*3] |=> !normal_request && !fast_request)
		else $error("request without cause");
	a_fast_first: assert property (fast_request |-> !normal_request)
		else $error("normal beside fast");
	a_fast_route: assert property ((soft_req & fast_select & chan_enable) != 32'h0 |=> fast_request)
		else $error("fast missing");
	a_cache_copy: assert property (1'b1 |=> branch_cache_entry == $past(vector_read_insn))
		else $error("cache entry stale");
	a_read_latch: assert property (s_read |-> s_latch)
		else $error("service not latched");
	a_drop_clear: assert property ($fell(normal_request) && !fast_request |=> !in_service)
		else $error("service stuck");
	a_normal_hold: assert property (in_service |-> normal_request || fast_request || $fell(normal_request))
		else $error("service without request");
endmodule
bind dvic_ctrl dvic_ctrl_props props_u (.clock, .reset, .req_in, .soft_req, .chan_enable, .fast_select,
	.vector_read_insn, .vector_read, .fast_request, .normal_request, .source_id, .branch_cache_entry, .in_service);

// *** dvic_core_model.sv ***
// Core stand-in that reads the vector of each normal request held past its lag
`timescale 1ns/100ps
module dvic_core_model #(
	parameter int LAG = 2
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Controller side
	input wire logic normal_request,
	input wire logic in_service,
	output logic vector_read
);
	logic [2:0] wait_q;
	// One read per request after a lag; reset masks the unknown start
	assign vector_read = !reset && wait_q == LAG;
	always_ff @(posedge clock) begin
		if (reset || !normal_request || in_service) begin
			wait_q <= 3'h0;
		end else if (wait_q <= LAG) begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule

// *** dvic_tb.sv ***
// Bench for the dual vectored interrupt controller
`timescale 1ns/100ps
module testbench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [31:0] req_in = 32'h0, soft_req = 32'h0, fast_select = 32'h0, vector_addr, branch_cache_entry;
	logic [31:0] chan_enable = 32'hffff_ffff, vector_read_insn = 32'h1234_5678;
	logic [127:0] channel_source;
	logic [1023:0] vector_table;
	logic [4:0] source_id;
	logic vector_read, fast_request, normal_request, in_service;
	int n_mismatch = 0, comparisons = 0;
	dvic_ctrl dut_u (.clock, .reset, .req_in, .soft_req, .chan_enable, .fast_select, .channel_source,
		.vector_table, .vector_read_insn, .vector_read, .fast_request, .normal_request, .source_id,
		.vector_addr, .branch_cache_entry, .in_service);
	dvic_core_model core_u (.clock, .reset, .normal_request, .in_service, .vector_read);
	// Clock and hang guard
	initial forever #20 clock = ~clock;
	initial begin
		#8000;
		n_mismatch++;
		close_out;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	// Short soft pulse, dropped before the core reads
	task automatic win(input logic [31:0] s, input logic [4:0] id);
		soft_req = s;
		step(1);
		chk(normal_request, 1'b1);
		chk(source_id, id);
		soft_req = 32'h0;
		step(3);
	endtask
	task automatic t_prio;
		win(32'h0001_0009, 5'h00);
		win(32'h0001_8000, 5'h0f);
		chan_enable = 32'hffff_fffe;
		win(32'h0000_0009, 5'h03);
		chan_enable = 32'hffff_ffff;
	endtask
	// Swap sources 0 and 9 inside the primary unit
	task automatic t_remap;
		channel_source[3:0] = 4'h9;
		channel_source[39:36] = 4'h0;
		win(32'h0000_0208, 5'h00);
		channel_source[3:0] = 4'h0;
		channel_source[39:36] = 4'h9;
	endtask
	task automatic t_fast;
		fast_select = 32'h0000_0020;
		soft_req = 32'h0000_00a0;
		step(1);
		chk(fast_request, 1'b1);
		chk(normal_request, 1'b0);
		soft_req = 32'h0;
		step(1);
		chk(fast_request, 1'b0);
		fast_select = 32'h0;
	endtask
	// Pin request through the synchroniser, then a full service
	task automatic t_pin;
		req_in = 32'h0010_0000;
		step(3);
		chk(source_id, 5'h14);
		chk(vector_addr, vector_table[640+:32]);
		step(6);
		chk(in_service, 1'b1);
		soft_req = 32'h0000_0001;
		req_in = 32'h0;
		step(1);
		chk(source_id, 5'h14);
		chk(vector_addr, vector_table[640+:32]);
		soft_req = 32'h0;
		step(4);
		chk(in_service, 1'b0);
	endtask
	// Cache entry follows the instruction word one cycle later
	task automatic t_cache;
		chk(branch_cache_entry, 32'h1234_5678);
		vector_read_insn = 32'h89ab_cdef;
		step(1);
		chk(branch_cache_entry, 32'h89ab_cdef);
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		for (int c = 0; c < 32; c++) begin
			channel_source[c*4+:4] = c[3:0];
			vector_table[c*32+:32] = 32'h8000_0000 + c * 4;
		end
		step(2);
		reset = 1'b0;
		step(1);
		t_cache;
		t_prio;
		t_remap;
		t_fast;
		t_pin;
		close_out;
	end
endmodule
